// ---- tse_top.v ----
// TCP server socket engine: eight sockets with state, event flags and ring pointers behind APB.
// Assumes the network side delivers parsed segments and accepts transmit segment descriptors,
// both on CLOCK_I; the byte datapath into the buffers lives outside this block.
`timescale 1ns/1ps
`include "tse_consts.vh"

// Functional notes
// (R1) Receive slot of socket k starts at 0xC000 plus k times 2 KB; offset mask 0x07FF.
// (R2) Eight independent sockets, each with its own state, flags and pointers.
// (R3) Host sets mode and port, then open moves the socket to initialized.
// (R4) Listening socket receiving SYN goes syn-received, sends SYN/ACK, then connects.
// (R5) Every arriving data segment sets the receive flag; enabled flags raise interrupt. Here only data taken in the established state sets it.
// (R6) Host clears receive flag by writing one, or polls received size instead.
// (R7) Received size is nonzero while unread data is held, zero otherwise.
// (R8) Data larger than free receive space is refused; connection pauses until room exists.
// (R9) Host copies data, advances receive read pointer, then issues receive command.
// (R10) Queued transmit data stays within its slot and is cut into MSS segments.
// (R11) Host issues no new send until the previous send completed.
// (R12) Device advances transmit read pointer by bytes sent; host retries any remainder.
// (R13) Host polls transmit free size until it covers the intended length.
// (R14) Host writes at masked offset, advances transmit write pointer, then sends.
// (R15) Peer FIN sets disconnect flag and moves socket to close-wait.
// (R16) Host issues disconnect when done or after a FIN arrived.
// (R17) Completed disconnect or close sets disconnect flag and state closed.
// (R18) Event flags raise an interrupt whenever the matching enable bit is set.
// (R19) Active-low interrupt output asserts when an enabled socket summary bit is set.
// (R20) Buffer location is slot base plus pointer ANDed with mask.
// (R21) Transmit slots start at 0x8000 and follow in 2 KB steps.
// (R22) Pointers are free-running 16-bit counters; placement uses masked low bits.
// (R23) Socket states use distinct fixed encodings.
module tse_top (
	// Clock and reset
	input  wire        CLOCK_I,
	input  wire        SYS_RST_I,
	// APB slave
	input  wire        PSEL_I,
	input  wire        PENABLE_I,
	input  wire        PWRITE_I,
	input  wire [15:0] PADDR_I,
	input  wire [31:0] PWDATA_I,
	output reg  [31:0] PRDATA_O,
	output wire        PREADY_O,
	output reg         PSLVERR_O,
	// Received segments from the network side
	input  wire        SEG_VALID_I,
	input  wire [2:0]  SEG_SOCKET_I,
	input  wire        SEG_SYN_I,
	input  wire        SEG_ACK_I,
	input  wire        SEG_FIN_I,
	input  wire [15:0] SEG_LEN_I,
	output wire        SEG_READY_O,
	output reg  [15:0] RX_WR_ADDR_O,
	// Transmit segment descriptors to the network side
	output reg         TX_SEG_VALID_O,
	output reg  [2:0]  TX_SEG_SOCKET_O,
	output reg  [1:0]  TX_SEG_KIND_O,
	output reg  [15:0] TX_SEG_ADDR_O,
	output reg  [15:0] TX_SEG_LEN_O,
	input  wire        TX_SEG_READY_I,
	// Interrupt
	output reg         INTERRUPT_OUT_N_O
);

	// ****************************************************************
	// Bus decode
	// ****************************************************************
	wire        acc_setup;
	wire        addr_ok;
	wire        wr_sock;
	wire        wr_glob;
	wire [2:0]  a_sock;
	wire [5:0]  a_ofs;
	reg  [7:0]  gie_reg;

	// True when the address falls in the per-socket window at the given offset.
	function sock_hit;
		input [15:0] a;
		input [5:0]  ofs;
		begin
			sock_hit = (a[15:10] == 6'h00) && !a[9] && (a[5:0] == ofs);
		end
	endfunction

	assign PREADY_O  = 1'b1;
	assign acc_setup = PSEL_I & ~PENABLE_I;
	assign addr_ok   = (PADDR_I[15:10] == 6'h00) && (PADDR_I[1:0] == 2'b00);
	assign wr_sock   = PSEL_I & PENABLE_I & PWRITE_I & addr_ok & ~PADDR_I[9];
	assign wr_glob   = PSEL_I & PENABLE_I & PWRITE_I & addr_ok & PADDR_I[9] & (PADDR_I[8:6] == 3'h0);
	assign a_sock    = PADDR_I[8:6];
	assign a_ofs     = PADDR_I[5:0];

	// ****************************************************************
	// Shared handshakes and per-socket buses
	// ****************************************************************
	wire         seg_take;
	wire         tx_take;
	wire [63:0]  state_bus;
	wire [63:0]  flags_bus;
	wire [63:0]  enable_bus;
	wire [31:0]  mode_bus;
	wire [127:0] port_bus;
	wire [127:0] mss_bus;
	wire [127:0] tx_rd_bus;
	wire [127:0] tx_wr_bus;
	wire [127:0] rx_rd_bus;
	wire [127:0] rx_wr_bus;
	wire [127:0] rx_size_bus;
	wire [127:0] rx_free_bus;
	wire [7:0]   want_bus;
	wire [7:0]   synack_bus;
	wire [7:0]   fin_bus;
	wire [7:0]   summary;
	wire [7:0]   seg_state;
	wire [15:0]  seg_free;
	wire [15:0]  rx_map_addr;
	wire [15:0]  tx_map_addr;
	wire [15:0]  tx_len;
	reg  [2:0]   sel;

	assign seg_state = state_bus[SEG_SOCKET_I*8 +: 8];
	assign seg_free  = rx_free_bus[SEG_SOCKET_I*16 +: 16];
	// Holding ready low is the pause: the peer side retries the same segment later.
	assign SEG_READY_O = !((SEG_LEN_I != 16'h0000) && (seg_state == `TSE_ST_EST) && (SEG_LEN_I > seg_free)); // (R8)
	assign seg_take    = SEG_VALID_I & SEG_READY_O;
	assign tx_take     = TX_SEG_VALID_O & TX_SEG_READY_I;

	// ****************************************************************
	// Socket slices
	// ****************************************************************
	genvar gi;
	generate
		for (gi = 0; gi < 8; gi = gi + 1) begin : gen_sock // (R2)
			reg  [3:0]  mode_reg;
			reg  [15:0] port_reg;
			reg  [7:0]  state_reg;
			reg  [7:0]  flags_reg;
			reg  [7:0]  enable_reg;
			reg  [15:0] mss_reg;
			reg  [15:0] tx_rd_reg;
			reg  [15:0] tx_wr_reg;
			reg  [15:0] rx_rd_reg;
			reg  [15:0] rx_wr_reg;
			reg  [15:0] rx_done_reg;
			reg         busy_reg;
			reg         synack_reg;
			reg         fin_reg;
			wire        w_hit;
			wire [7:0]  cmd;
			wire        seg;
			wire        txd;
			wire        rx_accept;
			wire        con_ev;
			wire        sent_all;
			wire [7:0]  fl_set;
			wire [7:0]  fl_clr;
			wire [15:0] rx_used;

			assign w_hit     = wr_sock && (a_sock == gi);
			assign cmd       = (w_hit && (a_ofs == `TSE_OFS_CMD)) ? PWDATA_I[7:0] : 8'h00;
			assign seg       = seg_take && (SEG_SOCKET_I == gi);
			assign txd       = tx_take && (TX_SEG_SOCKET_O == gi);
			assign rx_accept = seg && (state_reg == `TSE_ST_EST) && (SEG_LEN_I != 16'h0000);
			assign con_ev    = seg && SEG_ACK_I && (state_reg == `TSE_ST_SYNRECV) && !synack_reg;
			assign sent_all  = txd && (TX_SEG_KIND_O == `TSE_KIND_DATA) && (tx_rd_reg + TX_SEG_LEN_O == tx_wr_reg);
			assign rx_used   = rx_wr_reg - rx_done_reg; // (R22)

			assign fl_set[`TSE_FLAG_CON]    = con_ev;
			assign fl_set[`TSE_FLAG_DISCONNECT_CMD] = (seg && SEG_FIN_I && (state_reg == `TSE_ST_EST)) | // (R15)
				((cmd == `TSE_CMD_CLOSE) && (state_reg != `TSE_ST_CLOSED)) | // (R17)
				(txd && (TX_SEG_KIND_O == `TSE_KIND_FIN)); // (R17)
			assign fl_set[`TSE_FLAG_RECEIVE_DONE_CMD]   = rx_accept; // (R5)
			assign fl_set[3]                = 1'b0;
			assign fl_set[`TSE_FLAG_SENDOK] = sent_all;
			assign fl_set[7:5]              = 3'b000;
			assign fl_clr = (w_hit && (a_ofs == `TSE_OFS_FLAGS)) ? PWDATA_I[7:0] : 8'h00;

			always @(posedge CLOCK_I) begin
				if (SYS_RST_I) begin
					mode_reg    <= 4'h0;
					port_reg    <= 16'h0000;
					state_reg   <= `TSE_ST_CLOSED;
					flags_reg   <= 8'h00;
					enable_reg  <= `TSE_RST_ENABLE;
					mss_reg     <= `TSE_RST_MSS;
					tx_rd_reg   <= 16'h0000;
					tx_wr_reg   <= 16'h0000;
					rx_rd_reg   <= 16'h0000;
					rx_wr_reg   <= 16'h0000;
					rx_done_reg <= 16'h0000;
					busy_reg    <= 1'b0;
					synack_reg  <= 1'b0;
					fin_reg     <= 1'b0;
				end else begin
					// A hardware event in the clearing cycle survives the write of one.
					flags_reg <= (flags_reg & ~fl_clr) | fl_set; // (R5) (R15) (R17)
					if (w_hit && (a_ofs == `TSE_OFS_MODE))
						mode_reg <= PWDATA_I[3:0];
					if (w_hit && (a_ofs == `TSE_OFS_PORT))
						port_reg <= PWDATA_I[15:0];
					if (w_hit && (a_ofs == `TSE_OFS_ENABLE))
						enable_reg <= PWDATA_I[7:0];
					if (w_hit && (a_ofs == `TSE_OFS_MSS))
						mss_reg <= PWDATA_I[15:0];
					if (w_hit && (a_ofs == `TSE_OFS_TX_WR))
						tx_wr_reg <= PWDATA_I[15:0];
					if (w_hit && (a_ofs == `TSE_OFS_RX_RD))
						rx_rd_reg <= PWDATA_I[15:0];
					if (cmd == `TSE_CMD_RECEIVE_DONE_CMD)
						rx_done_reg <= rx_rd_reg;
					if (rx_accept)
						rx_wr_reg <= rx_wr_reg + SEG_LEN_I; // (R22)
					if (txd && (TX_SEG_KIND_O == `TSE_KIND_DATA))
						tx_rd_reg <= tx_rd_reg + TX_SEG_LEN_O; // (R12)
					if (sent_all)
						busy_reg <= 1'b0;
					if (txd && (TX_SEG_KIND_O == `TSE_KIND_SYNACK))
						synack_reg <= 1'b0;
					if ((cmd == `TSE_CMD_SEND) && !busy_reg &&
						((state_reg == `TSE_ST_EST) || (state_reg == `TSE_ST_CLOSEWAIT)))
						busy_reg <= 1'b1;
					if (cmd == `TSE_CMD_CLOSE) begin
						state_reg  <= `TSE_ST_CLOSED; // (R17)
						busy_reg   <= 1'b0;
						synack_reg <= 1'b0;
						fin_reg    <= 1'b0;
					end else if ((cmd == `TSE_CMD_OPEN) && (mode_reg == `TSE_MODE_TCP) &&
						(state_reg == `TSE_ST_CLOSED)) begin
						state_reg   <= `TSE_ST_INIT; // (R3)
						tx_rd_reg   <= 16'h0000;
						tx_wr_reg   <= 16'h0000;
						rx_rd_reg   <= 16'h0000;
						rx_wr_reg   <= 16'h0000;
						rx_done_reg <= 16'h0000;
					end else if ((cmd == `TSE_CMD_LISTEN) && (state_reg == `TSE_ST_INIT)) begin
						state_reg <= `TSE_ST_LISTEN;
					end else if ((cmd == `TSE_CMD_DISCONNECT_CMD) &&
						((state_reg == `TSE_ST_EST) || (state_reg == `TSE_ST_CLOSEWAIT))) begin
						state_reg <= `TSE_ST_FINWAIT;
						fin_reg   <= 1'b1;
						busy_reg  <= 1'b0;
					end else if (seg && SEG_SYN_I && (state_reg == `TSE_ST_LISTEN)) begin
						state_reg  <= `TSE_ST_SYNRECV; // (R4)
						synack_reg <= 1'b1; // (R4)
					end else if (con_ev) begin
						state_reg <= `TSE_ST_EST; // (R4)
					end else if (seg && SEG_FIN_I && (state_reg == `TSE_ST_EST)) begin
						state_reg <= `TSE_ST_CLOSEWAIT; // (R15)
					end else if (txd && (TX_SEG_KIND_O == `TSE_KIND_FIN)) begin
						state_reg <= `TSE_ST_CLOSED; // (R17)
						fin_reg   <= 1'b0;
					end
				end
			end

			assign state_bus[gi*8 +: 8]     = state_reg; // (R23)
			assign flags_bus[gi*8 +: 8]     = flags_reg;
			assign enable_bus[gi*8 +: 8]    = enable_reg;
			assign mode_bus[gi*4 +: 4]      = mode_reg;
			assign port_bus[gi*16 +: 16]    = port_reg;
			assign mss_bus[gi*16 +: 16]     = mss_reg;
			assign tx_rd_bus[gi*16 +: 16]   = tx_rd_reg;
			assign tx_wr_bus[gi*16 +: 16]   = tx_wr_reg;
			assign rx_rd_bus[gi*16 +: 16]   = rx_rd_reg;
			assign rx_wr_bus[gi*16 +: 16]   = rx_wr_reg;
			assign rx_size_bus[gi*16 +: 16] = rx_used; // (R7)
			assign rx_free_bus[gi*16 +: 16] = `TSE_BUF_SIZE - rx_used; // (R8)
			assign synack_bus[gi]           = synack_reg;
			assign fin_bus[gi]              = fin_reg;
			assign want_bus[gi]             = synack_reg | fin_reg | (busy_reg && (tx_wr_reg != tx_rd_reg));
			assign summary[gi]              = |(flags_reg & enable_reg); // (R18)
		end
	endgenerate

	// ****************************************************************
	// Address mapping and segmentation
	// ****************************************************************
	tse_addr_map #(
		.BASE   (`TSE_RX_BASE)
	) u_rx_map (
		.sock_i (SEG_SOCKET_I),
		.ptr_i  (rx_wr_bus[SEG_SOCKET_I*16 +: 16]),
		.addr_o (rx_map_addr)
	);

	tse_addr_map #(
		.BASE   (`TSE_TX_BASE)
	) u_tx_map (
		.sock_i (sel),
		.ptr_i  (tx_rd_bus[sel*16 +: 16]),
		.addr_o (tx_map_addr)
	);

	tse_seg_len u_seg_len (
		.wr_i   (tx_wr_bus[sel*16 +: 16]),
		.rd_i   (tx_rd_bus[sel*16 +: 16]),
		.mss_i  (mss_bus[sel*16 +: 16]),
		.len_o  (tx_len)
	);

	// ****************************************************************
	// Transmit arbiter
	// ****************************************************************
	integer k;

	// Lowest socket number wins; a fixed priority is cheap and the link is shared anyway.
	always @* begin
		sel = 3'h0;
		for (k = 7; k >= 0; k = k - 1) begin
			if (want_bus[k])
				sel = k[2:0];
		end
	end

	// One descriptor in flight; the next is chosen after it is taken, so pointers are settled.
	always @(posedge CLOCK_I) begin
		if (SYS_RST_I) begin
			TX_SEG_VALID_O  <= 1'b0;
			TX_SEG_SOCKET_O <= 3'h0;
			TX_SEG_KIND_O   <= `TSE_KIND_DATA;
			TX_SEG_ADDR_O   <= 16'h0000;
			TX_SEG_LEN_O    <= 16'h0000;
		end else if (tx_take) begin
			TX_SEG_VALID_O <= 1'b0;
		end else if (!TX_SEG_VALID_O && (|want_bus)) begin
			TX_SEG_VALID_O  <= 1'b1;
			TX_SEG_SOCKET_O <= sel;
			TX_SEG_ADDR_O   <= tx_map_addr; // (R21)
			if (synack_bus[sel]) begin
				TX_SEG_KIND_O <= `TSE_KIND_SYNACK; // (R4)
				TX_SEG_LEN_O  <= 16'h0000;
			end else if (fin_bus[sel]) begin
				TX_SEG_KIND_O <= `TSE_KIND_FIN;
				TX_SEG_LEN_O  <= 16'h0000;
			end else begin
				TX_SEG_KIND_O <= `TSE_KIND_DATA;
				TX_SEG_LEN_O  <= tx_len; // (R10)
			end
		end
	end

	// ****************************************************************
	// Receive address, interrupt and global registers
	// ****************************************************************
	always @(posedge CLOCK_I) begin
		if (SYS_RST_I) begin
			RX_WR_ADDR_O      <= `TSE_RX_BASE;
			INTERRUPT_OUT_N_O <= 1'b1;
			gie_reg           <= `TSE_RST_GIE;
		end else begin
			if (seg_take && (SEG_LEN_I != 16'h0000) && (seg_state == `TSE_ST_EST))
				RX_WR_ADDR_O <= rx_map_addr; // (R1)
			INTERRUPT_OUT_N_O <= ~|(summary & gie_reg); // (R19)
			if (wr_glob && (a_ofs == `TSE_OFS_GIE))
				gie_reg <= PWDATA_I[7:0];
		end
	end

	// ****************************************************************
	// Read path
	// ****************************************************************
	reg [31:0] rd_val;
	reg        rd_err;

	always @* begin
		rd_val = 32'h0000_0000;
		rd_err = 1'b0;
		if (!addr_ok) begin
			rd_err = 1'b1;
		end else if (PADDR_I[9]) begin
			if ((a_sock == 3'h0) && (a_ofs == `TSE_OFS_SUMMARY))
				rd_val = {24'h000000, summary};
			else if ((a_sock == 3'h0) && (a_ofs == `TSE_OFS_GIE))
				rd_val = {24'h000000, gie_reg};
			else
				rd_err = 1'b1;
		end else if (sock_hit(PADDR_I, `TSE_OFS_MODE))
			rd_val = {28'h0000000, mode_bus[a_sock*4 +: 4]};
		else if (sock_hit(PADDR_I, `TSE_OFS_CMD))
			rd_val = 32'h0000_0000;
		else if (sock_hit(PADDR_I, `TSE_OFS_FLAGS))
			rd_val = {24'h000000, flags_bus[a_sock*8 +: 8]};
		else if (sock_hit(PADDR_I, `TSE_OFS_STATE))
			rd_val = {24'h000000, state_bus[a_sock*8 +: 8]};
		else if (sock_hit(PADDR_I, `TSE_OFS_PORT))
			rd_val = {16'h0000, port_bus[a_sock*16 +: 16]};
		else if (sock_hit(PADDR_I, `TSE_OFS_ENABLE))
			rd_val = {24'h000000, enable_bus[a_sock*8 +: 8]};
		else if (sock_hit(PADDR_I, `TSE_OFS_TX_FREE))
			rd_val = {16'h0000, `TSE_BUF_SIZE - (tx_wr_bus[a_sock*16 +: 16] - tx_rd_bus[a_sock*16 +: 16])};
		else if (sock_hit(PADDR_I, `TSE_OFS_TX_RD))
			rd_val = {16'h0000, tx_rd_bus[a_sock*16 +: 16]};
		else if (sock_hit(PADDR_I, `TSE_OFS_TX_WR))
			rd_val = {16'h0000, tx_wr_bus[a_sock*16 +: 16]};
		else if (sock_hit(PADDR_I, `TSE_OFS_RX_SIZE))
			rd_val = {16'h0000, rx_size_bus[a_sock*16 +: 16]}; // (R7)
		else if (sock_hit(PADDR_I, `TSE_OFS_RX_RD))
			rd_val = {16'h0000, rx_rd_bus[a_sock*16 +: 16]};
		else if (sock_hit(PADDR_I, `TSE_OFS_RX_WR))
			rd_val = {16'h0000, rx_wr_bus[a_sock*16 +: 16]};
		else if (sock_hit(PADDR_I, `TSE_OFS_MSS))
			rd_val = {16'h0000, mss_bus[a_sock*16 +: 16]};
		else
			rd_err = 1'b1;
	end

	// Read data is captured in the setup cycle, so it reflects state one edge before the access edge.
	always @(posedge CLOCK_I) begin
		if (SYS_RST_I) begin
			PRDATA_O  <= 32'h0000_0000;
			PSLVERR_O <= 1'b0;
		end else if (acc_setup) begin
			PRDATA_O  <= PWRITE_I ? 32'h0000_0000 : rd_val;
			PSLVERR_O <= rd_err;
		end
	end

endmodule // tse_top

// ---- tse_consts.vh ----
// Constants for the TCP socket engine: buffer layout, register map, commands, flags and states.
// Assumes inclusion by bare name from every design file of the engine.
`ifndef TSE_CONSTS_VH
`define TSE_CONSTS_VH

// ****************************************************************
// Buffer layout
// ****************************************************************
`define TSE_RX_BASE      16'hc000
`define TSE_TX_BASE      16'h8000
`define TSE_BUF_SIZE     16'h0800
`define TSE_OFS_MASK     16'h07ff

// ****************************************************************
// Register map (byte offsets)
// ****************************************************************
`define TSE_OFS_MODE     6'h00
`define TSE_OFS_CMD      6'h04
`define TSE_OFS_FLAGS    6'h08
`define TSE_OFS_STATE    6'h0c
`define TSE_OFS_PORT     6'h10
`define TSE_OFS_ENABLE   6'h14
`define TSE_OFS_TX_FREE  6'h18
`define TSE_OFS_TX_RD    6'h1c
`define TSE_OFS_TX_WR    6'h20
`define TSE_OFS_RX_SIZE  6'h24
`define TSE_OFS_RX_RD    6'h28
`define TSE_OFS_RX_WR    6'h2c
`define TSE_OFS_MSS      6'h30
`define TSE_OFS_SUMMARY  6'h00
`define TSE_OFS_GIE      6'h04

// ****************************************************************
// Reset values
// ****************************************************************
`define TSE_RST_ENABLE   8'hff
`define TSE_RST_GIE      8'h00
`define TSE_RST_MSS      16'h05b4

// ****************************************************************
// Protocol mode, commands and flag bits
// ****************************************************************
`define TSE_MODE_TCP     4'h1
`define TSE_CMD_OPEN     8'h01
`define TSE_CMD_LISTEN   8'h02
`define TSE_CMD_DISCONNECT_CMD   8'h08
`define TSE_CMD_CLOSE    8'h10
`define TSE_CMD_SEND     8'h20
`define TSE_CMD_RECEIVE_DONE_CMD     8'h40
`define TSE_FLAG_CON     0
`define TSE_FLAG_DISCONNECT_CMD  1
`define TSE_FLAG_RECEIVE_DONE_CMD    2
`define TSE_FLAG_SENDOK  4

// ****************************************************************
// Socket states and transmit segment kinds
// ****************************************************************
`define TSE_ST_CLOSED    8'h00
`define TSE_ST_INIT      8'h01
`define TSE_ST_LISTEN    8'h02
`define TSE_ST_SYNRECV   8'h03
`define TSE_ST_EST       8'h04
`define TSE_ST_CLOSEWAIT 8'h05
`define TSE_ST_FINWAIT   8'h06
`define TSE_KIND_DATA    2'h0
`define TSE_KIND_SYNACK  2'h1
`define TSE_KIND_FIN     2'h2

`endif

// ---- tse_addr_map.v ----
// Physical buffer address of a socket pointer: base plus socket slot plus masked pointer.
// Assumes a fixed 2 KB slot per socket; purely combinational.
`timescale 1ns/1ps
`include "tse_consts.vh"

module tse_addr_map #(
	parameter [15:0] BASE = `TSE_RX_BASE
) (
	// Selection
	input  wire [2:0]  sock_i,
	input  wire [15:0] ptr_i,
	// Result
	output wire [15:0] addr_o
);

	// The pointer itself is never an address; only its low bits place the byte.
	assign addr_o = BASE + {2'b00, sock_i, 11'h000} + (ptr_i & `TSE_OFS_MASK); // (R1) (R20) (R21)

endmodule // tse_addr_map

// ---- tse_seg_len.v ----
// Length of the next transmit segment from the pending queue and the maximum segment size.
// Assumes free-running 16-bit pointers; purely combinational.
`timescale 1ns/1ps
`include "tse_consts.vh"

module tse_seg_len (
	// Queue pointers and limit
	input  wire [15:0] wr_i,
	input  wire [15:0] rd_i,
	input  wire [15:0] mss_i,
	// Result
	output wire [15:0] len_o
);

	wire [15:0] pend;
	wire [15:0] cap;

	assign pend  = wr_i - rd_i; // (R22)
	// A host that overruns the slot cannot make the engine read past it.
	assign cap   = (pend > `TSE_BUF_SIZE) ? `TSE_BUF_SIZE : pend; // (R10)
	assign len_o = ((mss_i != 16'h0000) && (cap > mss_i)) ? mss_i : cap; // (R10)

endmodule // tse_seg_len

// ---- tse_top_sva.sv ----
// Checker for the socket engine's segment and descriptor ports.
// Assumes one clock domain and the synchronous active-high reset.
`timescale 1ns/1ps
module tse_top_sva (
	// Clock and reset
	input wire        CLOCK_I,
	input wire        SYS_RST_I,
	// Segment side
	input wire        SEG_VALID_I,
	input wire [15:0] SEG_LEN_I,
	input wire        SEG_READY_O,
	input wire [15:0] RX_WR_ADDR_O,
	input wire        TX_SEG_VALID_O,
	input wire [2:0]  TX_SEG_SOCKET_O,
	input wire [1:0]  TX_SEG_KIND_O,
	input wire [15:0] TX_SEG_ADDR_O,
	input wire [15:0] TX_SEG_LEN_O,
	input wire        TX_SEG_READY_I,
	input wire        INTERRUPT_OUT_N_O
);
	default clocking cb @(posedge CLOCK_I); endclocking
	default disable iff (SYS_RST_I);
	sequence s_take; TX_SEG_VALID_O && TX_SEG_READY_I; endsequence
	sequence s_wait; TX_SEG_VALID_O && !TX_SEG_READY_I; endsequence
	property p_rx_slot; RX_WR_ADDR_O[15:14] == 2'b11; endproperty
	a_rx_slot: assert property (p_rx_slot) else $error("rx address outside slots");
	property p_tx_slot; TX_SEG_VALID_O |-> TX_SEG_ADDR_O[15:11] == {2'b10, TX_SEG_SOCKET_O}; endproperty
	a_tx_slot: assert property (p_tx_slot) else $error("tx address outside slot");
	property p_seg_len; s_take ##0 (TX_SEG_KIND_O == 2'h0) |-> TX_SEG_LEN_O != 16'h0 && TX_SEG_LEN_O <= 16'h0800; endproperty
	a_seg_len: assert property (p_seg_len) else $error("bad data length");
	property p_ctl_len; TX_SEG_VALID_O && TX_SEG_KIND_O != 2'h0 |-> TX_SEG_LEN_O == 16'h0; endproperty
	a_ctl_len: assert property (p_ctl_len) else $error("control length nonzero");
	property p_hold; s_wait |=> TX_SEG_VALID_O && $stable(TX_SEG_ADDR_O) && $stable(TX_SEG_LEN_O); endproperty
	a_hold: assert property (p_hold) else $error("descriptor changed");
	property p_drop; s_take |=> !TX_SEG_VALID_O; endproperty
	a_drop: assert property (p_drop) else $error("valid held after take");
	property p_pause; !SEG_READY_O |-> SEG_LEN_I != 16'h0; endproperty
	a_pause: assert property (p_pause) else $error("pause without data");
	property p_rx_step; !$stable(RX_WR_ADDR_O) |-> $past(SEG_VALID_I) && $past(SEG_READY_O); endproperty
	a_rx_step: assert property (p_rx_step) else $error("rx address moved alone");
	property p_irq_rst; $fell(SYS_RST_I) |-> INTERRUPT_OUT_N_O; endproperty
	a_irq_rst: assert property (p_irq_rst) else $error("interrupt after reset");
endmodule // tse_top_sva
bind tse_top tse_top_sva u_sva (.CLOCK_I, .SYS_RST_I, .SEG_VALID_I, .SEG_LEN_I, .SEG_READY_O, .RX_WR_ADDR_O,
	.TX_SEG_VALID_O, .TX_SEG_SOCKET_O, .TX_SEG_KIND_O, .TX_SEG_ADDR_O, .TX_SEG_LEN_O, .TX_SEG_READY_I,
	.INTERRUPT_OUT_N_O);

// ---- tse_net_model.sv ----
// Network side: takes transmit descriptors after a set delay, counts data ones.
// Assumes descriptors stand until taken.
`timescale 1ns/1ps
module tse_net_model (
	// Clock and reset
	input  wire        clk_i,
	input  wire        rst_i,
	// Descriptor handshake
	input  wire        valid_i,
	input  wire [1:0]  kind_i,
	input  int         dly_i,
	output logic       ready_o,
	output int         n_data_o
);
	int cnt;
	always @(posedge clk_i) begin
		if (rst_i) begin
			ready_o <= 1'b0;
			cnt <= 0;
			n_data_o <= 0;
		end else begin
			if (valid_i && ready_o && kind_i == 2'h0)
				n_data_o <= n_data_o + 1;
			if (valid_i && !ready_o && cnt >= dly_i) begin
				ready_o <= 1'b1;
				cnt <= 0;
			end else if (valid_i && !ready_o)
				cnt <= cnt + 1;
			else begin
				ready_o <= 1'b0;
				cnt <= 0;
			end
		end
	end
endmodule // tse_net_model

// ---- tb_tse_top.sv ----
// Testbench: APB host, segment driver and network model around the engine.
// Assumes the engine answers APB with no wait states.
`timescale 1ns/1ps
module tb_tse_top;
	logic        clk, rst, psel, pen, pwr, sv, ssyn, sack, sfin;
	logic        prdy, perr, srdy, tv, trdy, irq_n;
	logic [2:0]  ssk, tsk;
	logic [1:0]  tkd;
	logic [15:0] pa, slen, rxa, tad, tln;
	logic [31:0] pwd, prd, rv;
	int          num_errors, n_tests, n_data, dly;
	logic [15:0] ta [6] = '{16'h4c, 16'h54, 16'h58, 16'h64, 16'h70, 16'h204};
	logic [31:0] te [6] = '{32'h0, 32'hff, 32'h800, 32'h0, 32'h5b4, 32'h0};
	tse_top dut (.CLOCK_I(clk), .SYS_RST_I(rst), .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(pa),
		.PWDATA_I(pwd), .PRDATA_O(prd), .PREADY_O(prdy), .PSLVERR_O(perr), .SEG_VALID_I(sv), .SEG_SOCKET_I(ssk),
		.SEG_SYN_I(ssyn), .SEG_ACK_I(sack), .SEG_FIN_I(sfin), .SEG_LEN_I(slen), .SEG_READY_O(srdy),
		.RX_WR_ADDR_O(rxa), .TX_SEG_VALID_O(tv), .TX_SEG_SOCKET_O(tsk), .TX_SEG_KIND_O(tkd),
		.TX_SEG_ADDR_O(tad), .TX_SEG_LEN_O(tln), .TX_SEG_READY_I(trdy), .INTERRUPT_OUT_N_O(irq_n));
	tse_net_model net (.clk_i(clk), .rst_i(rst), .valid_i(tv), .kind_i(tkd), .dly_i(dly), .ready_o(trdy),
		.n_data_o(n_data));
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_tests++;
		if (g !== e) begin
			num_errors++;
			$display("[ERR] %0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwr <= w;
		pa <= a;
		pwd <= d;
		@(posedge clk);
		pen <= 1'b1;
		do @(posedge clk); while (prdy !== 1'b1);
		rv = prd;
		psel <= 1'b0;
		pen <= 1'b0;
	endtask
	task automatic r(input logic [15:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(rv, e);
	endtask
	task automatic wr(input logic [15:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	// Polls a flag word; the bound stands in for a hang of the engine.
	task automatic poll(input logic [15:0] a, input logic [31:0] m);
		repeat (60) begin
			apb(1'b0, a, 32'h0);
			if ((rv & m) === m)
				break;
		end
		chk(rv & m, m);
	endtask
	task automatic seg_on(input logic y, input logic k, input logic f, input logic [15:0] l);
		@(posedge clk);
		sv <= 1'b1;
		ssk <= 3'h1;
		ssyn <= y;
		sack <= k;
		sfin <= f;
		slen <= l;
	endtask
	task automatic seg_off;
		@(negedge clk);
		while (srdy !== 1'b1)
			@(negedge clk);
		@(posedge clk);
		sv <= 1'b0;
		@(negedge clk);
	endtask
	task automatic conclude;
		$display("checks %0d mismatches %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	initial begin
		#50000;
		num_errors++;
		conclude;
	end
	initial begin
		{rst, psel, pen, pwr, sv, ssyn, sack, sfin} = 8'h80;
		{ssk, pa, slen, pwd} = '0;
		dly = 0;
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		foreach (ta[i]) r(ta[i], te[i]);
		wr(16'h40, 32'h1);
		wr(16'h50, 32'h1388);
		wr(16'h44, 32'h1);
		r(16'h4c, 32'h1);
		wr(16'h44, 32'h2);
		r(16'h4c, 32'h2);
		seg_on(1'b1, 1'b0, 1'b0, 16'h0);
		seg_off;
		r(16'h4c, 32'h3);
		seg_on(1'b0, 1'b1, 1'b0, 16'h0);
		seg_off;
		r(16'h4c, 32'h4);
		seg_on(1'b0, 1'b0, 1'b0, 16'd100);
		seg_off;
		chk({16'h0, rxa}, 32'hc800);
		r(16'h48, 32'h5);
		r(16'h200, 32'h2);
		wr(16'h204, 32'h2);
		repeat (2) @(negedge clk);
		chk({31'h0, irq_n}, 32'h0);
		wr(16'h48, 32'hff);
		r(16'h48, 32'h0);
		repeat (2) @(negedge clk);
		chk({31'h0, irq_n}, 32'h1);
		seg_on(1'b0, 1'b0, 1'b0, 16'd1948);
		seg_off;
		chk({16'h0, rxa}, 32'hc864);
		r(16'h64, 32'h800);
		seg_on(1'b0, 1'b0, 1'b0, 16'h1);
		repeat (3) @(negedge clk);
		chk({31'h0, srdy}, 32'h0);
		wr(16'h68, 32'h800);
		wr(16'h44, 32'h40);
		seg_off;
		chk({16'h0, rxa}, 32'hc800);
		r(16'h64, 32'h1);
		dly = 3;
		wr(16'h70, 32'h4);
		r(16'h58, 32'h800);
		wr(16'h60, 32'ha);
		wr(16'h44, 32'h20);
		poll(16'h48, 32'h10);
		r(16'h5c, 32'ha);
		chk(n_data, 32'h3);
		wr(16'h48, 32'hff);
		seg_on(1'b0, 1'b0, 1'b1, 16'h0);
		seg_off;
		r(16'h4c, 32'h5);
		r(16'h48, 32'h2);
		wr(16'h48, 32'hff);
		wr(16'h44, 32'h8);
		poll(16'h48, 32'h2);
		r(16'h4c, 32'h0);
		wr(16'h48, 32'hff);
		wr(16'h44, 32'h1);
		r(16'h4c, 32'h1);
		wr(16'h44, 32'h10);
		r(16'h48, 32'h2);
		r(16'h4c, 32'h0);
		chk({31'h0, irq_n}, 32'h0);
		@(posedge clk);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		r(16'h204, 32'h0);
		chk({31'h0, irq_n}, 32'h1);
		r(16'h48, 32'h0);
		r(16'h1cc, 32'h0);
		r(16'h3c, 32'h0);
		chk({31'h0, perr}, 32'h1);
		conclude;
	end
endmodule // tb_tse_top
